/* rtl/ecs_pkg.sv */
//
// Operation
// - first extended capability header at 100h
// - further capabilities above 0FFh via next pointers
// - error, channel and power budget structures present
// - 128-phase arbitration table at 1C0h-1FCh
// - maker identifier read-only, overridable defaults
// - part identifier read-only, overridable defaults
package ecs_pkg;
   // -----------------------------------------------------------
   // offsets
   // -----------------------------------------------------------
   localparam logic [11:0] OFF_IDENT = 12'h000;
   localparam logic [11:0] OFF_ERR_HDR = 12'h100;
   localparam logic [11:0] OFF_ERR_CAPCTL = 12'h118;
   localparam logic [11:0] OFF_VC_HDR = 12'h140;
   localparam logic [11:0] OFF_VC_CAP1 = 12'h144;
   localparam logic [11:0] OFF_VC_CTLSTS = 12'h14c;
   localparam logic [11:0] OFF_SECOND_VC_CTRL = 12'h160;
   localparam logic [11:0] OFF_SECOND_VC_STS = 12'h164;
   localparam logic [11:0] OFF_ARB_BASE = 12'h1c0;
   localparam logic [11:0] OFF_ARB_LAST = 12'h1fc;
   localparam logic [11:0] OFF_PWR_HDR = 12'h20c;
   localparam logic [11:0] OFF_PWR_DATA = 12'h214;
   localparam logic [11:0] OFF_PWR_CAPS = 12'h218;
   localparam logic [11:0] OFF_ACS_HDR = 12'h220;
   localparam logic [11:0] OFF_ACS_CAPCTL = 12'h224;
   localparam logic [11:0] OFF_EGRESS = 12'h228;
   localparam logic [11:0] OFF_LTR_HDR = 12'h230;
   localparam logic [11:0] OFF_LTR_LAT = 12'h234;
   // -----------------------------------------------------------
   // capability ids and versions
   // -----------------------------------------------------------
   localparam logic [15:0] CAPID_ERR = 16'h0001;
   localparam logic [15:0] CAPID_VC = 16'h0002;
   localparam logic [15:0] CAPID_PWR = 16'h0004;
   localparam logic [15:0] CAPID_ACS = 16'h000d;
   localparam logic [15:0] CAPID_LTR = 16'h0018;
   localparam logic [3:0] CAP_VERSION = 4'h1;
   localparam logic [11:0] NEXT_NONE = 12'h000;
   // -----------------------------------------------------------
   // identity defaults, values arbitrary
   // -----------------------------------------------------------
   localparam logic [15:0] MAKER_ID_RST = 16'h1a2b;
   localparam logic [15:0] PART_ID_RST = 16'h3c4d;
   // -----------------------------------------------------------
   // reset values and writable masks
   // -----------------------------------------------------------
   localparam logic [31:0] ERR_CAPCTL_RST = 32'h0000_00a0;
   localparam logic [31:0] ERR_CAPCTL_WMASK = 32'h0000_0140;
   localparam logic [31:0] VC_CAP1_RST = 32'h0000_0001;
   localparam logic [31:0] VC_CTLSTS_WMASK = 32'h0000_000f;
   localparam logic [31:0] SECOND_VC_CTRL_RST = 32'h0100_0000;
   localparam logic [31:0] SECOND_VC_CTRL_WMASK = 32'h870e_00ff;
   localparam logic [31:0] PWR_CAPS_RST = 32'h0000_0001;
   localparam logic [31:0] ACS_CAPCTL_RST = 32'h0000_001f;
   localparam logic [31:0] ACS_CAPCTL_WMASK = 32'h001f_0000;
   localparam logic [31:0] LTR_LAT_WMASK = 32'h1fff_1fff;
   localparam int ARB_PHASES = 128;
   localparam int ARB_PHASE_BITS = 4;
   localparam int ARB_WORDS = 16;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } ecs_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } ecs_rsp_t;
endpackage : ecs_pkg

/* rtl/ecs_arb_table.sv */
`timescale 1ns/100ps
`default_nettype none
module ecs_arb_table
   import ecs_pkg::*;
#(
   parameter int WORDS = ARB_WORDS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr,
   input wire logic [3:0] idx,
   input wire logic [31:0] wdata,
   input wire logic [3:0] be,
   output logic [31:0] rdata
);
   // -----------------------------------------------------------
   // second_virtual_channel arbitration phases, 8 per word
   // -----------------------------------------------------------
   logic [31:0] mem_q [WORDS];
   logic [31:0] mem_d [WORDS];

   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi++) begin : g_word
         always_comb begin
            mem_d[gi] = mem_q[gi];
            if (wr && idx == 4'(gi)) begin
               for (int b = 0; b < 4; b++) begin
                  if (be[b]) begin
                     mem_d[gi][b*8 +: 8] = wdata[b*8 +: 8];
                  end
               end
            end
         end
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               mem_q[gi] <= 32'h0000_0000;
            end else begin
               mem_q[gi] <= mem_d[gi];
            end
         end
      end
   endgenerate

   assign rdata = mem_q[idx];
endmodule : ecs_arb_table
`default_nettype wire

/* rtl/ecs_ident.sv */
`timescale 1ns/100ps
`default_nettype none
module ecs_ident
   import ecs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic load,
   input wire logic [31:0] load_value,
   output logic [31:0] ident
);
   // -----------------------------------------------------------
   // identifiers: fixed defaults, replaced by smbus or eeprom load
   // -----------------------------------------------------------
   logic [31:0] id_q;
   logic [31:0] id_d;

   always_comb begin
      id_d = id_q;
      if (load) begin
         id_d = load_value;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         id_q <= {PART_ID_RST, MAKER_ID_RST};
      end else begin
         id_q <= id_d;
      end
   end

   assign ident = id_q;
endmodule : ecs_ident
`default_nettype wire

/* rtl/ecs_config_space.sv */
`timescale 1ns/100ps
`default_nettype none
module ecs_config_space
   import ecs_pkg::*;
#(
   parameter logic [11:0] PWR_NEXT = OFF_ACS_HDR
) (
   input wire logic mclk,
   input wire logic reset,
   input wire ecs_req_t req,
   input wire logic id_load,
   input wire logic [31:0] id_load_value,
   output ecs_rsp_t rsp,
   output logic [31:0] egress_vector,
   output logic [31:0] second_vc_ctrl
);
   // -----------------------------------------------------------
   // storage
   // -----------------------------------------------------------
   logic [31:0] err_q, err_d;
   logic [31:0] vcctl_q, vcctl_d;
   logic [31:0] second_vc_q, second_vc_d;
   logic [31:0] acs_q, acs_d;
   logic [31:0] egr_q, egr_d;
   logic [31:0] ltr_q, ltr_d;
   ecs_rsp_t rsp_q, rsp_d;
   logic [31:0] bmask;
   logic [31:0] arb_rdata;
   logic [31:0] ident;
   logic arb_hit;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         bmask[b*8 +: 8] = {8{req.be[b]}};
      end
   end

   assign arb_hit = req.addr >= OFF_ARB_BASE && req.addr <= OFF_ARB_LAST;

   ecs_arb_table #(.WORDS(ARB_WORDS)) u_arb (
      .mclk(mclk),
      .reset(reset),
      .wr(req.wr && arb_hit),
      .idx(req.addr[5:2]),
      .wdata(req.wdata),
      .be(req.be),
      .rdata(arb_rdata)
   );

   ecs_ident u_ident (
      .mclk(mclk),
      .reset(reset),
      .load(id_load),
      .load_value(id_load_value),
      .ident(ident)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] wm);
      merge = (old & ~wm) | (nw & wm);
   endfunction : merge

   function automatic logic [31:0] hdr(input logic [11:0] nxt, input logic [15:0] id);
      hdr = {nxt, CAP_VERSION, id};
   endfunction : hdr

   // -----------------------------------------------------------
   // writes
   // -----------------------------------------------------------
   always_comb begin
      err_d = err_q;
      vcctl_d = vcctl_q;
      second_vc_d = second_vc_q;
      acs_d = acs_q;
      egr_d = egr_q;
      ltr_d = ltr_q;
      if (req.wr) begin
         unique case (req.addr)
            OFF_ERR_CAPCTL: err_d = merge(err_q, req.wdata, ERR_CAPCTL_WMASK & bmask);
            OFF_VC_CTLSTS: vcctl_d = merge(vcctl_q, req.wdata, VC_CTLSTS_WMASK & bmask);
            OFF_SECOND_VC_CTRL:
               second_vc_d = merge(second_vc_q, req.wdata, SECOND_VC_CTRL_WMASK & bmask);
            OFF_ACS_CAPCTL: acs_d = merge(acs_q, req.wdata, ACS_CAPCTL_WMASK & bmask);
            OFF_EGRESS: egr_d = merge(egr_q, req.wdata, bmask);
            OFF_LTR_LAT: ltr_d = merge(ltr_q, req.wdata, LTR_LAT_WMASK & bmask);
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------
   // reads, answered one cycle later
   // -----------------------------------------------------------
   always_comb begin
      rsp_d.valid = req.rd;
      rsp_d.rdata = 32'h0000_0000;
      if (req.rd) begin
         if (arb_hit) begin
            rsp_d.rdata = arb_rdata;
         end else begin
            unique case (req.addr)
               OFF_IDENT: rsp_d.rdata = ident;
               OFF_ERR_HDR: rsp_d.rdata = hdr(OFF_VC_HDR, CAPID_ERR);
               OFF_ERR_CAPCTL: rsp_d.rdata = err_q;
               OFF_VC_HDR: rsp_d.rdata = hdr(OFF_PWR_HDR, CAPID_VC);
               OFF_VC_CAP1: rsp_d.rdata = VC_CAP1_RST;
               OFF_VC_CTLSTS: rsp_d.rdata = vcctl_q;
               OFF_SECOND_VC_CTRL: rsp_d.rdata = second_vc_q;
               OFF_SECOND_VC_STS: rsp_d.rdata = 32'h0000_0000;
               OFF_PWR_HDR: rsp_d.rdata = hdr(PWR_NEXT, CAPID_PWR);
               OFF_PWR_DATA: rsp_d.rdata = 32'h0000_0000;
               OFF_PWR_CAPS: rsp_d.rdata = PWR_CAPS_RST;
               OFF_ACS_HDR: rsp_d.rdata = hdr(NEXT_NONE, CAPID_ACS);
               OFF_ACS_CAPCTL: rsp_d.rdata = acs_q;
               OFF_EGRESS: rsp_d.rdata = egr_q;
               OFF_LTR_HDR: rsp_d.rdata = hdr(NEXT_NONE, CAPID_LTR);
               OFF_LTR_LAT: rsp_d.rdata = ltr_q;
               default: rsp_d.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         err_q <= ERR_CAPCTL_RST;
         vcctl_q <= 32'h0000_0000;
         second_vc_q <= SECOND_VC_CTRL_RST;
         acs_q <= ACS_CAPCTL_RST;
         egr_q <= 32'h0000_0000;
         ltr_q <= 32'h0000_0000;
         rsp_q <= '0;
      end else begin
         err_q <= err_d;
         vcctl_q <= vcctl_d;
         second_vc_q <= second_vc_d;
         acs_q <= acs_d;
         egr_q <= egr_d;
         ltr_q <= ltr_d;
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;
   assign egress_vector = egr_q;
   assign second_vc_ctrl = second_vc_q;
endmodule : ecs_config_space
`default_nettype wire

/* dv/ecs_config_space_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ecs_config_space_assertions
   import ecs_pkg::*;
#(
   parameter logic [11:0] PWR_NEXT = OFF_ACS_HDR
) (
   input wire logic mclk,
   input wire logic reset,
   input wire ecs_req_t req,
   input wire logic id_load,
   input wire logic [31:0] id_load_value,
   input wire ecs_rsp_t rsp,
   input wire logic [31:0] egress_vector,
   input wire logic [31:0] second_vc_ctrl
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (reset);
   a_read_answered: assert property (req.rd |=> rsp.valid)
      else $error("read not answered");
   a_no_stray_answer: assert property (!req.rd |=> !rsp.valid)
      else $error("answer without read");
   a_first_header: assert property (req.rd && req.addr == OFF_ERR_HDR
      |=> rsp.rdata == {OFF_VC_HDR, CAP_VERSION, CAPID_ERR}) else $error("bad header");
   a_channel_header: assert property (req.rd && req.addr == OFF_VC_HDR
      |=> rsp.rdata == {OFF_PWR_HDR, CAP_VERSION, CAPID_VC}) else $error("bad header");
   a_power_header: assert property (req.rd && req.addr == OFF_PWR_HDR
      |=> rsp.rdata == {PWR_NEXT, CAP_VERSION, CAPID_PWR}) else $error("bad header");
   a_last_header: assert property (req.rd && req.addr == OFF_LTR_HDR
      |=> rsp.rdata[31:20] == NEXT_NONE && rsp.rdata[15:0] == CAPID_LTR)
      else $error("bad header");
   a_reserved_zero: assert property (req.rd && req.addr == 12'h200
      |=> rsp.rdata == 32'h0) else $error("reserved read not zero");
   a_ident_load: assert property (id_load ##2 (req.rd && req.addr == OFF_IDENT)
      |=> rsp.rdata == $past(id_load_value, 3)) else $error("identifiers not loaded");
   a_egress_write: assert property (req.wr && req.addr == OFF_EGRESS && req.be == 4'hf
      |=> egress_vector == $past(req.wdata)) else $error("egress not written");
   a_second_vc_hold: assert property (!(req.wr && req.addr == OFF_SECOND_VC_CTRL)
      |=> $stable(second_vc_ctrl)) else $error("channel control changed");
endmodule : ecs_config_space_assertions
bind ecs_config_space ecs_config_space_assertions #(.PWR_NEXT(PWR_NEXT))
   i_ecs_config_space_assertions (.mclk(mclk), .reset(reset), .req(req), .id_load(id_load),
   .id_load_value(id_load_value), .rsp(rsp), .egress_vector(egress_vector),
   .second_vc_ctrl(second_vc_ctrl));
`default_nettype wire

/* dv/ecs_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ecs_host_model
   import ecs_pkg::*;
(
   input wire logic mclk,
   input wire ecs_rsp_t rsp,
   output var ecs_req_t req
);
   initial req = '{wr: 1'b0, rd: 1'b0, addr: 12'hffc, wdata: 32'h5a5a_5a5a, be: 4'h0};
   task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] b, output logic [31:0] q, output logic v);
      @(negedge mclk);
      req = '{wr: w, rd: !w, addr: a, wdata: d, be: b};
      @(negedge mclk);
      q = rsp.rdata;
      v = rsp.valid;
      // idle lines carry the inverse so stale values are never trusted
      req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d, be: ~b};
   endtask : access
endmodule : ecs_host_model
`default_nettype wire

/* dv/ecs_config_space_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ecs_config_space_test
   import ecs_pkg::*;
;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic id_load = 1'b0;
   logic [31:0] id_load_value = 32'h0;
   ecs_req_t req;
   ecs_rsp_t rsp, rsp_acs;
   logic [31:0] egress_vector, second_vc_ctrl, q;
   logic v;
   logic [11:0] ptr;
   int mismatches = 0;
   int tests_run = 0;
   logic [11:0] nxt [4] = '{OFF_VC_HDR, OFF_PWR_HDR, OFF_LTR_HDR, NEXT_NONE};
   logic [15:0] cid [4] = '{CAPID_ERR, CAPID_VC, CAPID_PWR, CAPID_LTR};
   logic [11:0] roff [5] = '{OFF_VC_CAP1, OFF_PWR_CAPS, OFF_SECOND_VC_STS, OFF_PWR_DATA, 12'h12c};
   logic [31:0] rval [5] = '{VC_CAP1_RST, PWR_CAPS_RST, 32'h0, 32'h0, 32'h0};
   logic [11:0] woff [11] = '{OFF_IDENT, OFF_ERR_HDR, OFF_ERR_CAPCTL, OFF_VC_CTLSTS,
      OFF_SECOND_VC_CTRL, OFF_ACS_CAPCTL, OFF_EGRESS, OFF_LTR_LAT, OFF_ARB_BASE, OFF_ARB_LAST,
      12'h200};
   logic [31:0] wmsk [11] = '{32'h0, 32'h0, ERR_CAPCTL_WMASK, VC_CTLSTS_WMASK,
      SECOND_VC_CTRL_WMASK, ACS_CAPCTL_WMASK, 32'hffff_ffff, LTR_LAT_WMASK, 32'hffff_ffff,
      32'hffff_ffff, 32'h0};
   logic [31:0] wrst [11] = '{{PART_ID_RST, MAKER_ID_RST}, {OFF_VC_HDR, CAP_VERSION, CAPID_ERR},
      ERR_CAPCTL_RST, 32'h0, SECOND_VC_CTRL_RST, ACS_CAPCTL_RST, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0};
   always #25 mclk = ~mclk;
   ecs_host_model i_ecs_host_model (.mclk(mclk), .rsp(rsp), .req(req));
   ecs_config_space #(.PWR_NEXT(OFF_LTR_HDR)) i_ecs_config_space (.mclk(mclk), .reset(reset),
      .req(req), .id_load(id_load), .id_load_value(id_load_value), .rsp(rsp),
      .egress_vector(egress_vector), .second_vc_ctrl(second_vc_ctrl));
   // second copy keeps the default power next pointer, fed the same requests
   ecs_config_space i_ecs_config_space_acs (.mclk(mclk), .reset(reset), .req(req),
      .id_load(id_load), .id_load_value(id_load_value), .rsp(rsp_acs), .egress_vector(),
      .second_vc_ctrl());
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask : check
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] b);
      i_ecs_host_model.access(w, a, d, b, q, v);
      check({31'h0, v}, {31'h0, !w});
   endtask : xfer
   initial begin
      #(3000 * 50);
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      check(egress_vector, 32'h0);
      check(second_vc_ctrl, SECOND_VC_CTRL_RST);
      // walk the capability chain from the first header
      ptr = OFF_ERR_HDR;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, ptr, 32'h0, 4'hf);
         check({31'h0, ptr > 12'h0ff}, 32'h1);
         check(q, {nxt[i], CAP_VERSION, cid[i]});
         ptr = q[31:20];
      end
      xfer(1'b0, OFF_ACS_HDR, 32'h0, 4'hf);
      check(q, {NEXT_NONE, CAP_VERSION, CAPID_ACS});
      xfer(1'b0, OFF_PWR_HDR, 32'h0, 4'hf);
      check(rsp_acs.rdata, {OFF_ACS_HDR, CAP_VERSION, CAPID_PWR});
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, roff[i], 32'h0, 4'hf);
         check(q, rval[i]);
      end
      // reset value, then all ones written, then only writable bits kept
      for (int i = 0; i < 11; i++) begin
         xfer(1'b0, woff[i], 32'h0, 4'hf);
         check(q, wrst[i]);
         xfer(1'b1, woff[i], 32'hffff_ffff, 4'hf);
         xfer(1'b0, woff[i], 32'h0, 4'hf);
         check(q, wmsk[i] | (wrst[i] & ~wmsk[i]));
      end
      check(egress_vector, 32'hffff_ffff);
      check(second_vc_ctrl,
            SECOND_VC_CTRL_WMASK | (SECOND_VC_CTRL_RST & ~SECOND_VC_CTRL_WMASK));
      xfer(1'b1, OFF_ARB_LAST, 32'h0, 4'h2);
      xfer(1'b0, OFF_ARB_LAST, 32'h0, 4'hf);
      check(q, 32'hffff_00ff);
      id_load = 1'b1;
      id_load_value = 32'h5e6f_7a8b;
      @(negedge mclk);
      id_load = 1'b0;
      xfer(1'b0, OFF_IDENT, 32'h0, 4'hf);
      check(q, 32'h5e6f_7a8b);
      give_verdict();
   end
endmodule : ecs_config_space_test
`default_nettype wire
